// ---- local_global_address_mapper.sv ----
// Purpose: maps core and debug local addresses to global space, holds paging registers
// Assumes: mode, debug state and request inputs come from logic on pclk
// Notes: APB slave with zero wait states; registers at four times their index
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module local_global_address_mapper
   import mapper_pkg::*;
#(
   parameter int RAM_BYTES = RAM_MAX_BYTES,
   parameter int PFL_BYTES = PFL_MAX_BYTES
)
(
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode and debug state
   input wire logic special_mode,
   input wire logic debug_active,
   input wire logic dbg_window_en,
   input wire logic dbg_cmd_running,
   // far call and return index path
   input wire logic farcall_we,
   input wire logic [3:0] farcall_index,
   // core request
   input wire logic cpu_req,
   input wire logic [15:0] cpu_local_addr,
   input wire logic cpu_direct,
   input wire logic cpu_debug_space,
   input wire logic cpu_firmware_cmd,
   output logic cpu_done,
   output logic [17:0] cpu_global_addr,
   output region_e cpu_region,
   // debug master request
   input wire logic dbg_req,
   input wire logic [15:0] dbg_local_addr,
   input wire logic dbg_direct,
   input wire logic debug_space_read,
   input wire logic debug_space_write,
   output logic dbg_done,
   output logic [17:0] dbg_global_addr,
   output region_e dbg_region,
   // system effects
   output logic illegal_access_reset,
   output logic debug_entry_req
);

   // ***************************************************
   // apb decode
   // ***************************************************
   logic [7:0] page_base_r;
   logic pb_locked_r;
   logic [3:0] window_r;
   logic [3:0] dbg_window_r;
   logic [31:0] prdata_r;
   logic cpu_fw_r;
   logic illegal_r;
   logic started_r;
   logic entry_r;

   wire setup_ph;
   wire access_ph;
   wire wr_access;
   wire hit_pb;
   wire hit_win;
   wire hit_dwin;
   wire hit_st;
   wire unmapped;
   wire pb_we;
   wire win_apb_we;
   wire dwin_we;
   wire dbg_sel_index;
   wire [3:0] dbg_index;
   wire [7:0] status;
   wire [31:0] rd_mux;

   // phase and address decode
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_access = access_ph & pwrite;
   assign hit_pb = (paddr == OFF_PAGE_BASE);
   assign hit_win = (paddr == OFF_WINDOW);
   assign hit_dwin = (paddr == OFF_DBG_WINDOW);
   assign hit_st = (paddr == OFF_STATUS);
   assign unmapped = ~(hit_pb | hit_win | hit_dwin | hit_st);

   // zero wait states, error on unmapped offsets
   assign pready = 1'b1;
   assign pslverr = access_ph & unmapped;

   // ***************************************************
   // page base register
   // ***************************************************
   // write once unless special
   assign pb_we = wr_access & hit_pb & (special_mode | ~pb_locked_r);

   // page base and its lock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         page_base_r <= PAGE_BASE_RST;
         pb_locked_r <= 1'b0;
      end
      else
      begin
         if (pb_we)
         begin
            page_base_r <= pwdata[7:0];
         end
         if (wr_access & hit_pb & ~special_mode)
         begin
            pb_locked_r <= 1'b1;
         end
      end
   end

   // ***************************************************
   // window index registers
   // ***************************************************
   assign win_apb_we = wr_access & hit_win;
   assign dwin_we = wr_access & hit_dwin;

   // instruction path wins, lands next edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         window_r <= WINDOW_RST;
      end
      else if (farcall_we)
      begin
         window_r <= farcall_index;
      end
      else if (win_apb_we)
      begin
         window_r <= pwdata[3:0];
      end
   end

   // debug window index, written by the debug master
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dbg_window_r <= DBG_WINDOW_RST;
      end
      else if (dwin_we)
      begin
         dbg_window_r <= pwdata[3:0];
      end
   end

   // ***************************************************
   // read path
   // ***************************************************
   // status shows lock, mode, debug and index choice
   assign status = {4'h0, dbg_sel_index, debug_active, special_mode, pb_locked_r};

   assign rd_mux = hit_pb ? {24'h000000, page_base_r} :
                   hit_win ? {28'h0000000, window_r} :
                   hit_dwin ? {28'h0000000, dbg_window_r} :
                   hit_st ? {24'h000000, status} : 32'h00000000;

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
      end
      else if (setup_ph & ~pwrite)
      begin
         prdata_r <= rd_mux;
      end
   end
   assign prdata = prdata_r;

   // ***************************************************
   // mapping paths
   // ***************************************************
   map_if cpu_m ();
   map_if dbg_m ();

   // debug index only when enabled and running
   assign dbg_sel_index = dbg_window_en & dbg_cmd_running;
   assign dbg_index = dbg_sel_index ? dbg_window_r : window_r;

   // one page base feeds both masters
   assign cpu_m.req = cpu_req;
   assign cpu_m.direct = cpu_direct;
   assign cpu_m.debug_cycle = cpu_debug_space;
   assign cpu_m.debug_active = debug_active;
   assign cpu_m.local_addr = cpu_local_addr;
   assign cpu_m.page_base = page_base_r;
   assign cpu_m.index = window_r;

   // debug path expands the same way
   assign dbg_m.req = dbg_req;
   assign dbg_m.direct = dbg_direct;
   assign dbg_m.debug_cycle = debug_space_read | debug_space_write;
   assign dbg_m.debug_active = debug_active;
   assign dbg_m.local_addr = dbg_local_addr;
   assign dbg_m.page_base = page_base_r;
   assign dbg_m.index = dbg_index;

   addr_map_unit #(
      .RAM_BYTES(RAM_BYTES),
      .PFL_BYTES(PFL_BYTES)
   ) cpu_map (
      .clk(pclk),
      .rst_n(presetn),
      .m(cpu_m.mapper)
   );

   addr_map_unit #(
      .RAM_BYTES(RAM_BYTES),
      .PFL_BYTES(PFL_BYTES)
   ) dbg_map (
      .clk(pclk),
      .rst_n(presetn),
      .m(dbg_m.mapper)
   );

   assign cpu_done = cpu_m.done;
   assign cpu_global_addr = cpu_m.global_addr;
   assign cpu_region = cpu_m.region;
   assign dbg_done = dbg_m.done;
   assign dbg_global_addr = dbg_m.global_addr;
   assign dbg_region = dbg_m.region;

   // ***************************************************
   // illegal access and debug entry
   // ***************************************************
   // core miss resets unless it is a firmware command, debug miss tolerated
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_fw_r <= 1'b0;
         illegal_r <= 1'b0;
      end
      else
      begin
         cpu_fw_r <= cpu_firmware_cmd;
         illegal_r <= cpu_m.done & (cpu_m.region == RG_NONE) & ~cpu_fw_r;
      end
   end
   assign illegal_access_reset = illegal_r;

   // special mode enters debug after reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         started_r <= 1'b0;
         entry_r <= 1'b0;
      end
      else
      begin
         started_r <= 1'b1;
         entry_r <= ~started_r & special_mode;
      end
   end
   assign debug_entry_req = entry_r;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence locked_write_s;
      wr_access && hit_pb && !special_mode && pb_locked_r;
   endsequence

   // later writes ignored in normal mode
   pb_lock_a: assert property (locked_write_s |=> $stable(page_base_r))
      else $error("page base changed after first write");

   pb_special_a: assert property (wr_access && hit_pb && special_mode
      |=> page_base_r == $past(pwdata[7:0]))
      else $error("page base write lost in special mode");

   // index read shows upper bits zero
   win_read_a: assert property (setup_ph && !pwrite && hit_win
      |=> prdata[31:4] == 28'h0000000 && prdata[3:0] == $past(window_r))
      else $error("window index read wrong");

   // instruction path write visible next cycle
   farcall_a: assert property (farcall_we |=> window_r == $past(farcall_index))
      else $error("far call index not written");

   // debug path uses the debug index when selected
   dbg_index_a: assert property (dbg_req && !dbg_direct && dbg_sel_index
      && dbg_local_addr[15:14] == QUAD_WINDOW
      |=> dbg_global_addr[17:14] == $past(dbg_window_r))
      else $error("debug index not used");

   // top page overlay during active debug
   dbg_top_a: assert property (cpu_req && cpu_debug_space && debug_active && !cpu_direct
      && cpu_local_addr[15:8] == DBG_PAGE_TOP
      |=> cpu_region == RG_DEBUG ##0 cpu_global_addr[17:8] == 10'h3FF)
      else $error("debug overlay missing at top page");

   // unimplemented core access resets two cycles on
   illegal_a: assert property (cpu_req && !cpu_firmware_cmd ##1 cpu_region == RG_NONE
      |=> illegal_access_reset)
      else $error("illegal access reset missing");

   fw_quiet_a: assert property (cpu_req && cpu_firmware_cmd |-> ##2 !illegal_access_reset)
      else $error("firmware access caused reset");

   entry_once_a: assert property (debug_entry_req |=> !debug_entry_req [*3])
      else $error("debug entry pulse repeated");
endmodule

// ---- mapper_pkg.sv ----
// Purpose: shared constants and types for the local to global address mapper
// Assumes: APB byte addresses are four times the register index
// Notes: global addresses are 18 bits, local addresses are 16 bits
package mapper_pkg;

   // ***************************************************
   // register map
   // ***************************************************
   localparam int PADDR_W = 10;
   localparam logic [7:0] IDX_PAGE_BASE = 8'h11;
   localparam logic [7:0] IDX_WINDOW = 8'h30;
   localparam logic [7:0] IDX_DBG_WINDOW = 8'h31;
   localparam logic [7:0] IDX_STATUS = 8'h32;
   localparam logic [9:0] OFF_PAGE_BASE = {IDX_PAGE_BASE, 2'b00};
   localparam logic [9:0] OFF_WINDOW = {IDX_WINDOW, 2'b00};
   localparam logic [9:0] OFF_DBG_WINDOW = {IDX_DBG_WINDOW, 2'b00};
   localparam logic [9:0] OFF_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [7:0] PAGE_BASE_RST = 8'h00;
   localparam logic [3:0] WINDOW_RST = 4'hE;
   localparam logic [3:0] DBG_WINDOW_RST = 4'hE;
   // status bit positions
   localparam int ST_LOCKED = 0;
   localparam int ST_SPECIAL = 1;
   localparam int ST_DEBUG = 2;
   localparam int ST_DBG_SEL = 3;

   // ***************************************************
   // paging and debug overlay
   // ***************************************************
   localparam logic [3:0] PAGE_LOW = 4'hC;
   localparam logic [3:0] PAGE_MID = 4'hD;
   localparam logic [3:0] PAGE_TOP = 4'hF;
   localparam logic [1:0] QUAD_WINDOW = 2'h2;
   localparam logic [7:0] DBG_PAGE_TOP = 8'hFF;
   localparam logic [7:0] DBG_PAGE_WIN = 8'hBF;
   localparam logic [3:0] DBG_WIN_INDEX = 4'hF;

   // ***************************************************
   // global resource placement
   // ***************************************************
   localparam logic [17:0] REGS_TOP = 18'h003FF;
   localparam logic [17:0] RAM_TOP = 18'h03FFF;
   localparam int RAM_BASE_I = 32'h0000_4000;
   localparam logic [17:0] DFL_LOW = 18'h04400;
   localparam logic [17:0] DFL_TOP = 18'h053FF;
   localparam logic [17:0] PFL_TOP = 18'h3FFFF;
   localparam int PFL_BASE_I = 32'h0004_0000;
   localparam int RAM_MAX_BYTES = 11 * 1024;
   localparam int PFL_MAX_BYTES = 224 * 1024;

   typedef enum logic [2:0]
   {
      RG_NONE = 3'b000,
      RG_REGS = 3'b001,
      RG_RAM = 3'b010,
      RG_DFLASH = 3'b011,
      RG_PFLASH = 3'b100,
      RG_DEBUG = 3'b101
   } region_e;

endpackage

// ---- map_if.sv ----
// Purpose: request and answer bundle between a bus master path and its mapper
// Assumes: both ends run on pclk
// Notes: answer fields come from the mapper's flip-flops
`timescale 1ns/100ps
interface map_if;
   import mapper_pkg::*;
   logic req;
   logic direct;
   logic debug_cycle;
   logic debug_active;
   logic [15:0] local_addr;
   logic [7:0] page_base;
   logic [3:0] index;
   logic done;
   logic [17:0] global_addr;
   region_e region;

   modport requester
   (
      output req, direct, debug_cycle, debug_active, local_addr, page_base, index,
      input done, global_addr, region
   );
   modport mapper
   (
      input req, direct, debug_cycle, debug_active, local_addr, page_base, index,
      output done, global_addr, region
   );
endinterface

// ---- addr_map_unit.sv ----
// Purpose: expands one local address into a global address and a resource
// Assumes: request fields are steady in the cycle that req is high
// Notes: answer appears one clock after the request
`timescale 1ns/100ps
module addr_map_unit
   import mapper_pkg::*;
#(
   parameter int RAM_BYTES = RAM_MAX_BYTES,
   parameter int PFL_BYTES = PFL_MAX_BYTES
)
(
   input wire logic clk,
   input wire logic rst_n,
   map_if.mapper m
);
   localparam logic [17:0] RAM_LOW = 18'(RAM_BASE_I - RAM_BYTES);
   localparam logic [17:0] PFL_LOW = 18'(PFL_BASE_I - PFL_BYTES);

   if (RAM_BYTES < 1 || RAM_BYTES > RAM_MAX_BYTES || PFL_BYTES < 1 || PFL_BYTES > PFL_MAX_BYTES)
   begin : bad_size
      $error("addr_map_unit: memory size out of range");
   end

   logic done_r;
   logic [17:0] ga_r;
   region_e region_r;
   wire [15:0] la;
   wire [3:0] page;
   wire [17:0] ga;
   wire dbg_hit;
   region_e region_nxt;

   // ***************************************************
   // local to global expansion
   // ***************************************************
   // direct page bits
   assign la = m.direct ? {m.page_base, m.local_addr[7:0]} : m.local_addr;
   assign page = (la[15:14] == 2'b00) ? PAGE_LOW :
                 (la[15:14] == 2'b01) ? PAGE_MID :
                 (la[15:14] == QUAD_WINDOW) ? m.index : PAGE_TOP;
   assign ga = {page, la[13:0]};
   assign dbg_hit = m.debug_active & m.debug_cycle &
                    ((la[15:8] == DBG_PAGE_TOP) |
                     ((la[15:8] == DBG_PAGE_WIN) & (m.index == DBG_WIN_INDEX)));
   assign region_nxt = dbg_hit ? RG_DEBUG :
                       (ga <= REGS_TOP) ? RG_REGS :
                       (ga >= RAM_LOW && ga <= RAM_TOP) ? RG_RAM :
                       (ga >= DFL_LOW && ga <= DFL_TOP) ? RG_DFLASH :
                       (ga >= PFL_LOW && ga <= PFL_TOP) ? RG_PFLASH : RG_NONE;

   // answer registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_r <= 1'b0;
         ga_r <= 18'h00000;
         region_r <= RG_NONE;
      end
      else
      begin
         done_r <= m.req;
         ga_r <= ga;
         region_r <= region_nxt;
      end
   end

   assign m.done = done_r;
   assign m.global_addr = ga_r;
   assign m.region = region_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   window_page_a: assert property (m.req && !m.direct && m.local_addr[15:14] == QUAD_WINDOW
      |=> m.global_addr == {$past(m.index), $past(m.local_addr[13:0])} && m.done)
      else $error("window address not built from index");
   fixed_low_a: assert property (m.req && !m.direct && m.local_addr[15:14] == 2'b00
      |=> m.global_addr[17:14] == PAGE_LOW)
      else $error("low fixed page wrong");
   direct_page_a: assert property (m.req && m.direct
      |=> m.global_addr[13:8] == $past(m.page_base[5:0]))
      else $error("direct page base not applied");
   debug_gate_a: assert property (m.region == RG_DEBUG
      |-> $past(m.debug_cycle) && $past(m.debug_active))
      else $error("debug overlay outside debug cycle");
endmodule

// ---- masters_model.sv ----
// Purpose: core and debug bus masters issuing mapping requests
// Assumes: tasks are entered just after a rising pclk edge
// Notes: released address lines show the inverse of their last value
`timescale 1ns/100ps
module masters_model
(
   input wire logic pclk,
   output logic cpu_req,
   output logic [15:0] cpu_local_addr,
   output logic cpu_direct,
   output logic cpu_debug_space,
   output logic cpu_firmware_cmd,
   output logic dbg_req,
   output logic [15:0] dbg_local_addr,
   output logic dbg_direct,
   output logic debug_space_read,
   output logic debug_space_write,
   output logic farcall_we,
   output logic [3:0] farcall_index
);
   // ******************
   // idle levels
   // ******************
   initial
   begin
      {cpu_req, cpu_direct, cpu_debug_space, cpu_firmware_cmd, dbg_req, dbg_direct} = '0;
      {debug_space_read, debug_space_write, farcall_we} = '0;
      {cpu_local_addr, dbg_local_addr, farcall_index} = '0;
   end

   // one request on one path, then a free cycle
   task automatic access(input logic dbg, input logic [15:0] a, input logic dir,
      input logic dsp, input logic fw);
      cpu_req <= !dbg;
      dbg_req <= dbg;
      cpu_local_addr <= a;
      dbg_local_addr <= a;
      cpu_direct <= dir;
      dbg_direct <= dir;
      cpu_debug_space <= dsp;
      debug_space_read <= dsp & !a[0];
      debug_space_write <= dsp & a[0];
      cpu_firmware_cmd <= fw;
      @(posedge pclk);
      cpu_req <= 1'b0;
      dbg_req <= 1'b0;
      cpu_local_addr <= ~a;
      dbg_local_addr <= ~a;
      @(posedge pclk);
   endtask

   // far call or return loading the window index
   task automatic far_call(input logic [3:0] ix);
      farcall_we <= 1'b1;
      farcall_index <= ix;
      @(posedge pclk);
      farcall_we <= 1'b0;
      farcall_index <= ~ix;
      @(posedge pclk);
   endtask
endmodule

// ---- local_global_address_mapper_tb_top.sv ----
// Purpose: self-checking bench for the local to global address mapper
// Assumes: zero wait APB slave, answers one clock after each request
// Notes: smaller RAM and program flash sizes expose both region bottoms
`timescale 1ns/100ps
module local_global_address_mapper_tb_top
   import mapper_pkg::*;
;
   localparam int RAMB = 8192;
   localparam int PFLB = 131072;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, seed = 32'h0FCA5DDC;
   logic special_mode, debug_active, dbg_window_en, dbg_cmd_running, farcall_we;
   logic [3:0] farcall_index, idx, didx;
   logic cpu_req, cpu_direct, cpu_debug_space, cpu_firmware_cmd, cpu_done;
   logic dbg_req, dbg_direct, debug_space_read, debug_space_write, dbg_done;
   logic [15:0] cpu_local_addr, dbg_local_addr;
   logic [17:0] cpu_global_addr, dbg_global_addr;
   region_e cpu_region, dbg_region;
   logic illegal_access_reset, debug_entry_req, ill_exp;
   logic [7:0] pb;
   logic [32:0] rq[$];
   logic [21:0] mq[$];
   logic [19:0] edges [12] = '{20'h0_8000, 20'h0_83FF, 20'h0_8400, 20'h0_9FFF, 20'h0_A000,
      20'h1_83FF, 20'h1_8400, 20'h1_93FF, 20'h1_9400, 20'h7_BFFF, 20'h8_8000, 20'hF_BFFF};
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   masters_model masters
   (
      .pclk, .cpu_req, .cpu_local_addr, .cpu_direct, .cpu_debug_space, .cpu_firmware_cmd,
      .dbg_req, .dbg_local_addr, .dbg_direct, .debug_space_read, .debug_space_write,
      .farcall_we, .farcall_index
   );

   local_global_address_mapper #(.RAM_BYTES(RAMB), .PFL_BYTES(PFLB)) uut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .special_mode, .debug_active, .dbg_window_en, .dbg_cmd_running,
      .farcall_we, .farcall_index, .cpu_req, .cpu_local_addr, .cpu_direct,
      .cpu_debug_space, .cpu_firmware_cmd, .cpu_done, .cpu_global_addr, .cpu_region,
      .dbg_req, .dbg_local_addr, .dbg_direct, .debug_space_read, .debug_space_write,
      .dbg_done, .dbg_global_addr, .dbg_region, .illegal_access_reset, .debug_entry_req
   );

   // ******************
   // checking helpers
   // ******************
   task automatic check(input logic ok, input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (!ok)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
      check(got === exp, got, exp);
   endtask

   task automatic cmp_map(input logic [20:0] got, input logic [20:0] exp);
      check(got === exp, 33'(got), 33'(exp));
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      check(got === exp, 33'(got), 33'(exp));
   endtask

   task automatic close_out();
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected {illegal, region, global} for one request
   function automatic logic [21:0] note(input logic [15:0] la, input logic [3:0] ix,
      input logic dsp, input logic chk);
      logic [3:0] pg;
      logic [17:0] g;
      logic [2:0] r;
      pg = la[15] ? (la[14] ? 4'hF : ix) : (la[14] ? 4'hD : 4'hC);
      g = {pg, la[13:0]};
      r = RG_NONE;
      if (int'(g) >= 32'h0004_0000 - PFLB)
         r = RG_PFLASH;
      if (g >= 18'h04400 && g <= 18'h053FF)
         r = RG_DFLASH;
      if (int'(g) >= 32'h0000_4000 - RAMB && g <= 18'h03FFF)
         r = RG_RAM;
      if (g <= 18'h003FF)
         r = RG_REGS;
      if (debug_active && dsp && (la[15:8] == 8'hFF || (la[15:8] == 8'hBF && ix == 4'hF)))
         r = RG_DEBUG;
      return {chk && r == RG_NONE, r, g};
   endfunction

   // ******************
   // drivers
   // ******************
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [9:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, xs());
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic map(input logic dbg, input logic [15:0] a, input logic dir, input logic dsp,
      input logic fw);
      logic [3:0] ix;
      ix = (dbg && dbg_window_en && dbg_cmd_running) ? didx : idx;
      mq.push_back(note(dir ? {pb, a[7:0]} : a, ix, dsp, !dbg && !fw));
      masters.access(dbg, a, dir, dsp, fw);
   endtask

   task automatic do_reset(input logic sm);
      presetn <= 1'b0;
      special_mode <= sm;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      {pb, idx, didx} = {8'h00, 4'hE, 4'hE};
      repeat (2) @(posedge pclk);
      cmp_flag(debug_entry_req, sm);
   endtask

   // takes the oldest note whenever a result shows
   always @(posedge pclk)
   begin
      logic [32:0] r;
      logic [21:0] m;
      if (!presetn)
         ill_exp = 1'b0;
      else
      begin
         cmp_flag(illegal_access_reset, ill_exp);
         ill_exp = 1'b0;
         if (psel && penable && pready === 1'b1 && !pwrite)
         begin
            r = rq.pop_front();
            cmp_rd({pslverr, prdata}, r);
         end
         if (cpu_done === 1'b1 || dbg_done === 1'b1)
         begin
            m = mq.pop_front();
            ill_exp = cpu_done & m[21];
            cmp_map(cpu_done ? {cpu_region, cpu_global_addr} : {dbg_region, dbg_global_addr},
               m[20:0]);
         end
      end
   end

   // clock and hang limit
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         close_out();
      end
   end

   // ******************
   // scenarios
   // ******************
   initial
   begin
      logic [31:0] r;
      {presetn, psel, penable, pwrite, special_mode, ill_exp} = '0;
      {debug_active, dbg_window_en, dbg_cmd_running, paddr, pwdata} = '0;
      do_reset(1'b0);
      rd(OFF_PAGE_BASE, 33'h0);
      rd(OFF_WINDOW, 33'hE);
      rd(OFF_DBG_WINDOW, 33'hE);
      rd(10'h3FC, 33'h1_0000_0000);
      wr(OFF_WINDOW, 32'hFFFF_FFF7);
      idx = 4'h7;
      rd(OFF_WINDOW, 33'h7);
      wr(OFF_PAGE_BASE, 32'h80);
      wr(OFF_PAGE_BASE, 32'h40);
      pb = 8'h80;
      rd(OFF_PAGE_BASE, 33'h80);
      rd(OFF_STATUS, 33'h1);
      map(1'b0, 16'h5A23, 1'b1, 1'b0, 1'b0);
      foreach (edges[i])
      begin
         idx = edges[i][19:16];
         wr(OFF_WINDOW, {28'h0, idx});
         map(1'b0, edges[i][15:0], 1'b0, 1'b0, 1'b0);
      end
      repeat (40)
      begin
         r = xs();
         idx = r[3:0];
         wr(OFF_WINDOW, r);
         map(1'b0, r[31:16], r[5], 1'b0, r[4]);
      end
      map(1'b0, 16'hFFFE, 1'b0, 1'b0, 1'b0);
      masters.far_call(4'h9);
      idx = 4'h9;
      map(1'b0, 16'h8100, 1'b0, 1'b0, 1'b0);
      debug_active <= 1'b1;
      wr(OFF_WINDOW, 32'hF);
      idx = 4'hF;
      map(1'b0, 16'hFF10, 1'b0, 1'b1, 1'b0);
      map(1'b0, 16'hFF10, 1'b0, 1'b0, 1'b0);
      map(1'b0, 16'hBF10, 1'b0, 1'b1, 1'b0);
      wr(OFF_WINDOW, 32'hE);
      idx = 4'hE;
      map(1'b0, 16'hBF10, 1'b0, 1'b1, 1'b0);
      wr(OFF_DBG_WINDOW, 32'h5);
      didx = 4'h5;
      dbg_window_en <= 1'b1;
      dbg_cmd_running <= 1'b1;
      @(posedge pclk);
      rd(OFF_STATUS, 33'hD);
      map(1'b1, 16'h8100, 1'b0, 1'b0, 1'b0);
      map(1'b1, 16'hFF01, 1'b0, 1'b1, 1'b0);
      map(1'b1, 16'hFF02, 1'b0, 1'b1, 1'b0);
      map(1'b1, 16'h0010, 1'b1, 1'b0, 1'b0);
      map(1'b1, 16'h8400, 1'b0, 1'b0, 1'b0);
      dbg_cmd_running <= 1'b0;
      @(posedge pclk);
      map(1'b1, 16'h8100, 1'b0, 1'b0, 1'b0);
      debug_active <= 1'b0;
      do_reset(1'b1);
      wr(OFF_PAGE_BASE, 32'h12);
      wr(OFF_PAGE_BASE, 32'h34);
      pb = 8'h34;
      rd(OFF_PAGE_BASE, 33'h34);
      rd(OFF_STATUS, 33'h2);
      map(1'b0, 16'h9977, 1'b1, 1'b0, 1'b0);
      // let the last answers drain, then every note must have been taken
      repeat (2) @(posedge pclk);
      cmp_flag(mq.size() == 0 && rq.size() == 0, 1'b1);
      close_out();
   end
endmodule
